//--- logic/byte_fifo_mem.v
// Purpose: byte FIFO memory with registered read data
// Assumes: none; a push when full or a pop when empty is ignored
// Notes: depth need not be a power of two; pop_data valid the cycle after pop
module byte_fifo_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 80,
  parameter AW = 7
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // write side
  input wire push,
  input wire [WIDTH-1:0] push_data,
  // read side
  input wire pop,
  output reg [WIDTH-1:0] pop_data,
  // level
  output reg [AW:0] count,
  output wire full,
  output wire empty
);
  localparam [AW-1:0] LAST = DEPTH[AW-1:0] - 1'b1;
  localparam [AW:0] CAP = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign full = (count == CAP);
  assign empty = (count == {(AW+1){1'b0}});

  always @(posedge hclk) begin
    if (do_push) begin
      mem[wptr] <= push_data;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      pop_data <= {WIDTH{1'b0}};
    end else begin
      if (do_push) begin
        wptr <= (wptr == LAST) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (do_pop) begin
        pop_data <= mem[rptr];
        rptr <= (rptr == LAST) ? {AW{1'b0}} : rptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

//--- logic/pd_crc32.v
// Purpose: bytewise reflected CRC-32 for transmitted packets
// Assumes: bytes are fed in line order, low bit first
// Notes: clear has priority over update; caller sends the inverted value
`include "pd_framer_regs.vh"
module pd_crc32 (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire clear,
  input wire update,
  input wire [7:0] data,
  // result
  output reg [31:0] crc
);
  reg [31:0] next_crc;
  integer i;

  always @* begin
    next_crc = crc;
    for (i = 0; i < 8; i = i + 1) begin
      if (next_crc[0] ^ data[i]) begin
        next_crc = (next_crc >> 1) ^ `CRC_POLY_REFL;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= `CRC_INIT;
    end else if (clear) begin
      crc <= `CRC_INIT;
    end else if (update) begin
      crc <= next_crc;
    end
  end
endmodule

//--- logic/pd_fifo_token_framer.v
// Purpose: token-driven framer between host FIFO bytes and PD line symbols
// Assumes: line symbol sink and packet receiver run on hclk
// Notes: registers over AHB-Lite; reads take one wait state, writes none
//
// Contract
// [RULE1] token 100xxxxx: low five bits count data
// [RULE2] software keeps packed count within two to thirty
// [RULE3] send low nibble then high, 4b5b encoded
// [RULE4] crc token inserts hardware crc into stream
// [RULE5] eop token sends end-of-packet symbol
// [RULE6] driver-off token disables transmit driver
// [RULE7] receive fifo holds 80 bytes, several packets
// [RULE8] sop packet gets leading tag 111
// [RULE9] sop prime tagged 110, only when enabled
// [RULE10] sop double prime tagged 101, when enabled
// [RULE11] sop prime debug tagged 100, when enabled
// [RULE12] sop double prime debug tagged 011, enabled
// [RULE13] tags 010, 001, 000 are reserved
// [RULE14] one token completes before next is fetched
// [RULE15] fifo register write pushes, read pops
// [RULE16] start command byte starts the transmitter
// [RULE17] crc covers packed bytes since packet start
`include "pd_framer_regs.vh"
module pd_fifo_token_framer #(
  parameter RX_DEPTH = `RX_DEPTH,
  parameter TX_DEPTH = `TX_DEPTH
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // line symbol transmit
  output reg [4:0] tx_sym,
  output reg tx_sym_valid,
  input wire tx_sym_ready,
  output reg tx_driver_en,
  // decoded receive stream
  input wire rx_sop_valid,
  input wire [2:0] rx_sop_type,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire rx_end
);
  localparam S_IDLE = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_DECODE = 3'd2;
  localparam S_DFETCH = 3'd3;
  localparam S_DLOAD = 3'd4;
  localparam S_SEND = 3'd5;
  localparam S_EOP = 3'd6;

  // fifo wiring
  wire [7:0] tx_head, rx_head;
  wire [7:0] rx_count;
  wire [6:0] tx_count;
  wire tx_full, tx_empty, rx_full, rx_empty;
  reg tx_push, tx_pop, rx_push, rx_pop;
  reg [7:0] tx_push_data, rx_push_data;
  // crc wiring
  wire [31:0] crc;
  reg crc_clear, crc_update;
  reg [7:0] crc_data;
  // bus state
  reg wr_pend, rd_pend, rd_popped, start_pulse, rx_overflow;
  reg [3:0] acc_addr, rx_enable;
  reg [4:0] host_pack_left;
  // transmit state
  reg [2:0] state;
  reg [4:0] data_left;
  reg [31:0] shifter;
  reg [3:0] nib_left;
  // receive state
  reg rx_active, rx_type_ok;
  reg [2:0] rx_tag;

  wire addr_ok = hsel && hready && htrans[1];
  wire can_load = !tx_sym_valid || tx_sym_ready;

  function [4:0] enc4b5b;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: enc4b5b = 5'h1E;
        4'h1: enc4b5b = 5'h09;
        4'h2: enc4b5b = 5'h14;
        4'h3: enc4b5b = 5'h15;
        4'h4: enc4b5b = 5'h0A;
        4'h5: enc4b5b = 5'h0B;
        4'h6: enc4b5b = 5'h0E;
        4'h7: enc4b5b = 5'h0F;
        4'h8: enc4b5b = 5'h12;
        4'h9: enc4b5b = 5'h13;
        4'hA: enc4b5b = 5'h16;
        4'hB: enc4b5b = 5'h17;
        4'hC: enc4b5b = 5'h1A;
        4'hD: enc4b5b = 5'h1B;
        4'hE: enc4b5b = 5'h1C;
        default: enc4b5b = 5'h1D;
      endcase
    end
  endfunction

  byte_fifo_mem #(.WIDTH(8), .DEPTH(TX_DEPTH), .AW(6)) u_tx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(tx_push),
    .push_data(tx_push_data),
    .pop(tx_pop),
    .pop_data(tx_head),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  // 80 bytes absorb several short packets back to back
  byte_fifo_mem #(.WIDTH(8), .DEPTH(RX_DEPTH), .AW(7)) u_rx_fifo ( // RULE7
    .hclk(hclk),
    .hresetn(hresetn),
    .push(rx_push),
    .push_data(rx_push_data),
    .pop(rx_pop),
    .pop_data(rx_head),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  pd_crc32 u_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(crc_clear),
    .update(crc_update),
    .data(crc_data),
    .crc(crc)
  );

  // host side of the fifo register
  always @* begin
    rx_pop = 1'b0;
    tx_push = 1'b0;
    tx_push_data = hwdata[7:0];
    if (addr_ok && !hwrite && haddr[3:0] == `FIFO_ADDR && !rx_empty) begin
      rx_pop = 1'b1; // RULE15
    end
    if (wr_pend && acc_addr == `FIFO_ADDR && !tx_full) begin
      // data bytes after a packed token bypass the start-command match
      if (host_pack_left != 5'h00 || hwdata[7:0] != `CMD_TX_START) begin
        tx_push = 1'b1; // RULE15
      end
    end
  end

  // ahb-lite slave
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_addr <= 4'h0;
      rd_popped <= 1'b0;
      rx_enable <= `CTRL_RESET;
      start_pulse <= 1'b0;
      host_pack_left <= 5'h00;
    end else begin
      start_pulse <= 1'b0;
      wr_pend <= 1'b0;
      if (addr_ok) begin
        acc_addr <= haddr[3:0];
        wr_pend <= hwrite;
        rd_pend <= !hwrite;
        rd_popped <= rx_pop;
        if (!hwrite) begin
          hreadyout <= 1'b0;
        end
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
        case (acc_addr)
          `FIFO_ADDR: hrdata <= rd_popped ? {24'h000000, rx_head} : 32'h00000000;
          `CTRL_ADDR: hrdata <= {27'h0000000, rx_enable, 1'b0};
          `STATUS_ADDR: hrdata <= {16'h0000, rx_count, 1'b0, rx_overflow, tx_driver_en,
                                   state != S_IDLE, rx_full, rx_empty, tx_full, tx_empty};
          default: hrdata <= 32'h00000000;
        endcase
      end
      if (wr_pend) begin
        case (acc_addr)
          `FIFO_ADDR: begin
            if (host_pack_left != 5'h00) begin
              host_pack_left <= host_pack_left - 5'h01;
            end else if (hwdata[7:0] == `CMD_TX_START) begin
              start_pulse <= 1'b1; // RULE16
            end else if (hwdata[7:5] == `TOK_PACKED) begin
              host_pack_left <= hwdata[4:0]; // RULE1
            end
          end
          `CTRL_ADDR: begin
            rx_enable <= hwdata[`CTRL_EN_LSB+3:`CTRL_EN_LSB];
            start_pulse <= hwdata[`CTRL_START_BIT]; // RULE16
          end
          default: begin
          end
        endcase
      end
    end
  end

  // transmit token engine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      tx_sym <= 5'h00;
      tx_sym_valid <= 1'b0;
      tx_driver_en <= 1'b0;
      data_left <= 5'h00;
      shifter <= 32'h00000000;
      nib_left <= 4'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_pulse) begin
            tx_driver_en <= 1'b1;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (!tx_empty) begin
            state <= S_DECODE; // RULE14
          end
        end
        S_DECODE: begin
          if (tx_head[7:5] == `TOK_PACKED) begin
            data_left <= tx_head[4:0]; // RULE1
            state <= (tx_head[4:0] == 5'h00) ? S_FETCH : S_DFETCH;
          end else if (tx_head == `TOK_CRC) begin
            shifter <= ~crc; // RULE4
            nib_left <= 4'h8;
            state <= S_SEND;
          end else if (tx_head == `TOK_EOP) begin
            state <= S_EOP; // RULE5
          end else if (tx_head == `TOK_DRIVER_OFF) begin
            tx_driver_en <= 1'b0; // RULE6
            state <= S_IDLE;
          end else begin
            // tokens this framer does not handle are consumed and skipped
            state <= S_FETCH;
          end
        end
        S_DFETCH: begin
          if (!tx_empty) begin
            state <= S_DLOAD;
          end
        end
        S_DLOAD: begin
          shifter <= {24'h000000, tx_head};
          nib_left <= 4'h2;
          data_left <= data_left - 5'h01;
          state <= S_SEND;
        end
        S_SEND: begin
          if (can_load) begin
            if (nib_left != 4'h0) begin
              tx_sym <= enc4b5b(shifter[3:0]); // RULE3
              tx_sym_valid <= 1'b1;
              shifter <= {4'h0, shifter[31:4]};
              nib_left <= nib_left - 4'h1;
            end else begin
              tx_sym_valid <= 1'b0;
              state <= (data_left != 5'h00) ? S_DFETCH : S_FETCH; // RULE14
            end
          end
        end
        S_EOP: begin
          if (can_load) begin
            tx_sym <= `SYM_EOP; // RULE5
            tx_sym_valid <= 1'b1;
            nib_left <= 4'h0;
            state <= S_SEND;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // fifo pops and crc feed for the engine
  always @* begin
    tx_pop = ((state == S_FETCH) || (state == S_DFETCH)) && !tx_empty;
    crc_update = (state == S_DLOAD); // RULE17
    crc_data = tx_head;
    // restart the crc at transmit start and when it is loaded for sending
    crc_clear = (state == S_IDLE && start_pulse) || (state == S_DECODE && tx_head == `TOK_CRC); // RULE17
  end

  // receive tagging
  always @* begin
    case (rx_sop_type)
      3'd0: begin
        rx_tag = `TAG_SOP; // RULE8
        rx_type_ok = 1'b1;
      end
      3'd1: begin
        rx_tag = `TAG_PRIME; // RULE9
        rx_type_ok = rx_enable[0];
      end
      3'd2: begin
        rx_tag = `TAG_DPRIME; // RULE10
        rx_type_ok = rx_enable[1];
      end
      3'd3: begin
        rx_tag = `TAG_PRIME_DEBUG; // RULE11
        rx_type_ok = rx_enable[2];
      end
      3'd4: begin
        rx_tag = `TAG_DPRIME_DEBUG; // RULE12
        rx_type_ok = rx_enable[3];
      end
      default: begin
        rx_tag = `TAG_SOP;
        rx_type_ok = 1'b0;
      end
    endcase
    rx_push = 1'b0;
    rx_push_data = rx_byte;
    if (rx_sop_valid && rx_type_ok) begin
      rx_push = 1'b1;
      // low five bits carry no meaning
      rx_push_data = {rx_tag, 5'h00};
    end else if (rx_byte_valid && rx_active) begin
      rx_push = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_active <= 1'b0;
      rx_overflow <= 1'b0;
    end else begin
      if (rx_sop_valid) begin
        rx_active <= rx_type_ok;
      end else if (rx_end) begin
        rx_active <= 1'b0;
      end
      // a byte lost to a full fifo wins over the software clear
      if (rx_push && rx_full) begin
        rx_overflow <= 1'b1;
      end else if (wr_pend && acc_addr == `STATUS_ADDR && hwdata[`ST_RX_OVF]) begin
        rx_overflow <= 1'b0;
      end
    end
  end
endmodule

//--- logic/pd_framer_regs.vh
// Purpose: constants shared by the token framer, its CRC unit, the bench and its checker
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: byte addresses, field positions, token codes and line symbols
`ifndef PD_FRAMER_REGS_VH
`define PD_FRAMER_REGS_VH

// register byte addresses
`define FIFO_ADDR 4'h0
`define CTRL_ADDR 4'h4
`define STATUS_ADDR 4'h8

// control fields
`define CTRL_START_BIT 0
`define CTRL_EN_LSB 1
`define CTRL_RESET 4'h0

// status fields
`define ST_TX_EMPTY 0
`define ST_TX_FULL 1
`define ST_RX_EMPTY 2
`define ST_RX_FULL 3
`define ST_TX_BUSY 4
`define ST_DRIVER 5
`define ST_RX_OVF 6
`define ST_RX_CNT_LSB 8

// transmit tokens
`define TOK_PACKED 3'h4
`define TOK_CRC 8'hFF
`define TOK_EOP 8'h14
`define TOK_DRIVER_OFF 8'hFE
`define CMD_TX_START 8'hA1

// receive leading-byte tags, top three bits
`define TAG_SOP 3'h7
`define TAG_PRIME 3'h6
`define TAG_DPRIME 3'h5
`define TAG_PRIME_DEBUG 3'h4
`define TAG_DPRIME_DEBUG 3'h3

// line symbols and crc
`define SYM_EOP 5'h0D
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY_REFL 32'hEDB88320

// fifo sizes
`define RX_DEPTH 80
`define TX_DEPTH 48

`endif

//--- sim/pd_fifo_token_framer_tb_top.sv
// Purpose: self-checking bench for the fifo token framer
// Assumes: one AHB-Lite master, hready fed back from hreadyout
// Notes: expected symbols and crc are built here from the token rules
`include "pd_framer_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t got %h want %h", $time, a, b); end end
module pd_fifo_token_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic stall = 1'h0;
  wire hreadyout, hresp, tx_sym_valid, tx_sym_ready, tx_driver_en, rx_sop_valid, rx_byte_valid, rx_end;
  wire [31:0] hrdata;
  wire [4:0] tx_sym;
  wire [2:0] rx_sop_type;
  wire [7:0] rx_byte;
  int miscompares = 0;
  int checks = 0;
  logic [4:0] exp [$];
  logic [4:0] enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [2:0] tags [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3};
  always #10 hclk = ~hclk;
  pd_fifo_token_framer i_dut (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_sym, .tx_sym_valid, .tx_sym_ready,
    .tx_driver_en, .rx_sop_valid, .rx_sop_type, .rx_byte_valid, .rx_byte, .rx_end);
  pd_port_partner i_partner (.hclk, .tx_sym, .tx_sym_valid, .tx_sym_ready, .stall, .rx_sop_valid,
    .rx_sop_type, .rx_byte_valid, .rx_byte, .rx_end);
  // entered just after a rising edge; hready is sampled at rising edges, before the slave updates it
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr <= {28'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'h0, a, 32'h0, q);
  endtask
  task tx_pkt(input int n, input logic by_ctrl);
    logic [31:0] c;
    logic [31:0] q;
    logic [7:0] b;
    c = 32'hFFFFFFFF;
    wr(`FIFO_ADDR, 32'h80 | n);
    for (int i = 0; i < n; i++) begin
      // a first byte equal to the start command must stay data
      b = (i == 0) ? 8'hA1 : 8'(i * 37 + 5);
      wr(`FIFO_ADDR, {24'h0, b});
      exp.push_back(enc[b[3:0]]);
      exp.push_back(enc[b[7:4]]);
      c = c ^ {24'h0, b};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    c = ~c;
    for (int i = 0; i < 8; i++) exp.push_back(enc[c[4*i+:4]]);
    exp.push_back(5'h0D);
    wr(`FIFO_ADDR, 32'hFF);
    wr(`FIFO_ADDR, 32'h14);
    wr(`FIFO_ADDR, 32'hFE);
    `CHK(tx_driver_en, 1'h0)
    if (by_ctrl) wr(`CTRL_ADDR, 32'h1);
    else wr(`FIFO_ADDR, 32'hA1);
    for (int k = 0; k < 3000 && !(i_partner.got.size() >= exp.size() && tx_driver_en === 1'h0); k++)
      @(posedge hclk);
    `CHK(i_partner.got.size(), exp.size())
    foreach (exp[i]) `CHK(i_partner.got[i], exp[i])
    rd(`STATUS_ADDR, q);
    `CHK(q[5:0], 6'h05)
    i_partner.got.delete();
    exp.delete();
  endtask
  task pkt(input logic [2:0] t, input int n);
    i_partner.pulse(2'h0, {5'h0, t});
    for (int i = 0; i < n; i++) i_partner.pulse(2'h1, 8'(i + t));
    i_partner.pulse(2'h2, 8'h0);
  endtask
  task final_report;
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    final_report;
  end
  initial begin
    logic [31:0] q;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    `CHK(tx_driver_en, 1'h0)
    tx_pkt(2, 1'h0);
    stall <= 1'h1;
    tx_pkt(30, 1'h1);
    stall <= 1'h0;
    wr(`CTRL_ADDR, 32'h1E);
    rd(`CTRL_ADDR, q);
    `CHK(q, 32'h1E)
    for (int t = 0; t < 5; t++) pkt(3'(t), 2);
    for (int t = 0; t < 5; t++) begin
      rd(`FIFO_ADDR, q);
      `CHK(q[7:5], tags[t])
      for (int i = 0; i < 2; i++) begin
        rd(`FIFO_ADDR, q);
        `CHK(q[7:0], 8'(i + t))
      end
    end
    wr(`CTRL_ADDR, 32'h0);
    for (int t = 1; t < 6; t++) pkt(3'(t), 1);
    pkt(3'h0, 1);
    rd(`STATUS_ADDR, q);
    `CHK(q[14:8], 7'h02)
    rd(`FIFO_ADDR, q);
    `CHK(q[7:5], 3'h7)
    rd(`FIFO_ADDR, q);
    `CHK(q[7:0], 8'h00)
    // four packets fill the fifo exactly, a fifth overflows
    for (int p = 0; p < 5; p++) pkt(3'h0, p < 4 ? 19 : 1);
    rd(`STATUS_ADDR, q);
    `CHK(q[14:8], 7'h50)
    `CHK({q[6], q[3]}, 2'h3)
    for (int k = 0; k < 80; k++) begin
      rd(`FIFO_ADDR, q);
      if (k % 20 == 0)
        `CHK(q[7:5], 3'h7)
      else
        `CHK(q[7:0], 8'(k % 20 - 1))
    end
    rd(`FIFO_ADDR, q);
    `CHK(q, 32'h0)
    rd(4'hC, q);
    `CHK(q, 32'h0)
    wr(`STATUS_ADDR, 32'h40);
    rd(`STATUS_ADDR, q);
    `CHK(q[7:0], 8'h05)
    final_report;
  end
endmodule

//--- sim/pd_framer_chk.sv
// Purpose: port-level checks for the fifo token framer
// Assumes: hready is fed back from hreadyout
// Notes: one clock domain, so default clocking and disable are used
`include "pd_framer_regs.vh"
module pd_framer_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // line side
  input wire [4:0] tx_sym,
  input wire tx_sym_valid,
  input wire tx_sym_ready,
  input wire tx_driver_en
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = hsel && hready && htrans[1];
  wire acc = tx_sym_valid && tx_sym_ready;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OKAY: assert property (hresp == 1'h0)
    else $error("error response seen");
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  AST_HRDATA_HOLD: assert property (!$rose(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside an answer");
  AST_SYM_HOLD: assert property (tx_sym_valid && !tx_sym_ready |=> tx_sym_valid && $stable(tx_sym))
    else $error("symbol dropped before acceptance");
  AST_SYM_CODE: assert property (tx_sym_valid |-> tx_sym inside {5'h1E, 5'h09, 5'h14, 5'h15,
    5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D, `SYM_EOP})
    else $error("illegal line symbol");
  AST_SEND_DRIVEN: assert property (tx_sym_valid |-> tx_driver_en)
    else $error("symbol sent with driver off");
  AST_EOP_GAP: assert property (acc && tx_sym == `SYM_EOP |=> !tx_sym_valid)
    else $error("next token acted on without a fetch");
  AST_OFF_QUIET: assert property ($fell(tx_driver_en) |-> !tx_sym_valid ##1 !tx_sym_valid)
    else $error("symbols after driver off");
  CV_READ: cover property (take && !hwrite);
  CV_STALL: cover property (tx_sym_valid && !tx_sym_ready);
  CV_EOP: cover property (acc && tx_sym == `SYM_EOP);
  CV_OFF: cover property ($fell(tx_driver_en));
endmodule
bind pd_fifo_token_framer pd_framer_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .tx_sym, .tx_sym_valid, .tx_sym_ready, .tx_driver_en);

//--- sim/pd_port_partner.sv
// Purpose: port partner model on the framer's line side
// Assumes: symbols and decoded receive events are exchanged on hclk
// Notes: stall makes the sink take a symbol only every other cycle
module pd_port_partner (
  // clock
  input wire hclk,
  // symbol sink
  input wire [4:0] tx_sym,
  input wire tx_sym_valid,
  output logic tx_sym_ready,
  input wire stall,
  // decoded receive events
  output logic rx_sop_valid,
  output logic [2:0] rx_sop_type,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] got [$];
  initial begin
    tx_sym_ready = 1'h0;
    rx_sop_valid = 1'h0;
    rx_sop_type = 3'h0;
    rx_byte_valid = 1'h0;
    rx_byte = 8'h0;
    rx_end = 1'h0;
  end
  always @(posedge hclk) begin
    if (tx_sym_valid && tx_sym_ready)
      got.push_back(tx_sym);
    tx_sym_ready <= stall ? ~tx_sym_ready : 1'h1;
  end
  // kind 0 ordered set, 1 byte, 2 end; released lines invert so stale data never looks valid
  task pulse(input logic [1:0] kind, input logic [7:0] d);
    @(posedge hclk);
    rx_sop_valid <= kind == 2'h0;
    rx_sop_type <= d[2:0];
    rx_byte_valid <= kind == 2'h1;
    rx_byte <= d;
    rx_end <= kind == 2'h2;
    @(posedge hclk);
    rx_sop_valid <= 1'h0;
    rx_byte_valid <= 1'h0;
    rx_end <= 1'h0;
    rx_sop_type <= ~d[2:0];
    rx_byte <= ~d;
  endtask
endmodule
